// *** loop_mon_pkg.sv ***
// Constants, register map and state codes for the safety loop monitor
package loop_mon_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned CYC_PER_US      = CLK_HZ / 1_000_000;
    localparam int unsigned CYC_PER_MS      = CLK_HZ / 1_000;
    // Half period of the test square wave, one evaluation per half
    localparam int unsigned TEST_HALF_US    = 2500;
    localparam int unsigned TEST_HALF_CYC   = TEST_HALF_US * CYC_PER_US;
    // Least closure of the reset contact
    localparam int unsigned RST_CLOSE_MS    = 80;
    localparam int unsigned RST_CLOSE_CYC   = RST_CLOSE_MS * CYC_PER_MS;
    // Response limits, input change to output change
    localparam int unsigned ACT_MAX_MS      = 40;
    localparam int unsigned ACT_MAX_CYC     = ACT_MAX_MS * CYC_PER_MS;
    localparam int unsigned DEACT_MAX_MS    = 38;
    localparam int unsigned DEACT_MAX_CYC   = DEACT_MAX_MS * CYC_PER_MS;
    // Consecutive good evaluations before the loop counts as valid
    localparam logic [1:0]  GOOD_EVALS      = 2'h2;
    localparam int unsigned CNT_W           = 24;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0]  CTRL_OFS        = 8'h00;
    localparam logic [7:0]  STATUS_OFS      = 8'h04;
    localparam logic [7:0]  IRQ_STAT_OFS    = 8'h08;
    localparam logic [7:0]  IRQ_MASK_OFS    = 8'h0c;

    // Control fields
    localparam int unsigned CTRL_FORCE_BIT  = 0;
    localparam logic        CTRL_RST_VAL    = 1'h0;

    // Status fields
    localparam int unsigned ST_VALID_BIT    = 0;
    localparam int unsigned ST_ACTIVE_BIT   = 1;
    localparam int unsigned ST_INFO_BIT     = 2;
    localparam int unsigned ST_AUTO_BIT     = 3;
    localparam int unsigned ST_EVEN_BIT     = 4;
    localparam int unsigned ST_TX_BIT       = 5;
    localparam int unsigned ST_MODE2_BIT    = 6;

    // Interrupt fields
    localparam int unsigned IRQ_W           = 3;
    localparam int unsigned IRQ_FAULT_BIT   = 0;
    localparam int unsigned IRQ_ON_BIT      = 1;
    localparam int unsigned IRQ_RESET_BIT   = 2;
    localparam logic [2:0]  IRQ_RST_VAL     = 3'h0;

    // ------------------------------------------------------------
    // Output group states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_OPEN = 2'b01,
        ST_ON   = 2'b10
    } out_state_e;

endpackage

// *** loop_tester.sv ***
// Test square wave generator and return signal evaluator
`timescale 1ns/100ps
module loop_tester #(
    parameter int unsigned HALF_CYC = loop_mon_pkg::TEST_HALF_CYC
) (
    input  wire logic clk_i,            // System clock
    input  wire logic rst_i,            // Synchronous reset, high
    input  wire logic loop_receive_i,   // Returned test signal
    input  wire logic parity_select_i,  // High: even sensor count
    output logic      loop_transmit_o,  // Test signal out
    output logic      eval_o,           // Evaluation strobe
    output logic      eval_ok_o,        // Last evaluation matched
    output logic      loop_valid_o      // Loop judged valid
);
    logic [loop_mon_pkg::CNT_W-1:0] cnt_r;
    logic                           tx_r;
    logic                           ok_r;
    logic [1:0]                     good_r;
    logic                           at_end;
    logic                           expected;
    logic                           match;

    assign at_end   = (cnt_r == loop_mon_pkg::CNT_W'(HALF_CYC - 1));
    assign expected = parity_select_i ? tx_r : ~tx_r;
    assign match    = (loop_receive_i == expected);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= '0;
            tx_r  <= 1'b0;
        end else if (at_end) begin
            cnt_r <= '0;
            tx_r  <= ~tx_r;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ok_r   <= 1'b0;
            good_r <= 2'h0;
        end else if (at_end) begin
            ok_r   <= match;
            good_r <= !match ? 2'h0 :
                      (good_r == loop_mon_pkg::GOOD_EVALS) ? good_r : good_r + 2'h1;
        end
    end

    assign loop_transmit_o = tx_r;
    assign eval_o          = at_end;
    assign eval_ok_o       = ok_r;
    assign loop_valid_o    = (good_r == loop_mon_pkg::GOOD_EVALS);

    a_bad_invalid: assert property (@(posedge clk_i) disable iff (rst_i)
        at_end && !match |=> !loop_valid_o) else $error("loop stayed valid after bad sample");
    a_tx_toggles: assert property (@(posedge clk_i) disable iff (rst_i)
        at_end |=> (tx_r != $past(tx_r))) else $error("test signal did not toggle");
endmodule

// *** reset_detect.sv ***
// Reset contact supervision: qualified closure followed by release
`timescale 1ns/100ps
module reset_detect #(
    parameter int unsigned CLOSE_CYC = loop_mon_pkg::RST_CLOSE_CYC
) (
    input  wire logic clk_i,        // System clock
    input  wire logic rst_i,        // Synchronous reset, high
    input  wire logic closed_i,     // Reset contact closed
    output logic      accept_o      // Pulse on qualified release
);
    logic [loop_mon_pkg::CNT_W-1:0] cnt_r;
    logic                           prev_r;
    logic                           long_enough;
    logic                           acc_r;

    assign long_enough = (cnt_r >= loop_mon_pkg::CNT_W'(CLOSE_CYC));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r  <= '0;
            prev_r <= 1'b0;
            acc_r  <= 1'b0;
        end else begin
            prev_r <= closed_i;
            acc_r  <= prev_r && !closed_i && long_enough;
            if (!closed_i)
                cnt_r <= '0;
            else if (!long_enough)
                cnt_r <= cnt_r + 1'b1;
        end
    end

    assign accept_o = acc_r;

    a_short_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
        accept_o |-> $past(long_enough) && !$past(closed_i)) else $error("short closure accepted");
endmodule

// *** safety_loop_monitor.sv ***
// Top of the dynamic safety loop monitor with its Wishbone register file
// Behaviour
// - Drive square wave, evaluate returned signal
// - Each sensor inverts; check returned inversion
// - Parity strap selects even or odd count
// - Manual reset needs closure then opening
// - Auto reset activates once loop valid
// - Two safety outputs switch together
// - Info output, behaviour set by switch
// - Position 1: info high when reset
// - Position 2: high if loop closed, unreset
// - Feedback contacts in reset path block reset
// - Activate under 40 ms, release under 38
// - Evaluate return at least 200 per second
// - Lost test signal opens the outputs
`timescale 1ns/100ps
module safety_loop_monitor #(
    parameter int unsigned HALF_CYC  = loop_mon_pkg::TEST_HALF_CYC,
    parameter int unsigned CLOSE_CYC = loop_mon_pkg::RST_CLOSE_CYC
) (
    input  wire logic        clk_i,             // System clock, 50 MHz
    input  wire logic        rst_i,             // Synchronous reset, high
    // Wishbone slave
    input  wire logic        wb_cyc_i,          // Bus cycle
    input  wire logic        wb_stb_i,          // Strobe
    input  wire logic        wb_we_i,           // Write enable
    input  wire logic [7:0]  wb_adr_i,          // Byte address
    input  wire logic [3:0]  wb_sel_i,          // Byte lanes
    input  wire logic [31:0] wb_dat_i,          // Write data
    output logic [31:0]      wb_dat_o,          // Read data
    output logic             wb_ack_o,          // Acknowledge
    // Safety loop
    output logic             loop_transmit_o,   // Test signal out
    input  wire logic        loop_receive_i,    // Test signal back
    input  wire logic        parity_select_i,   // High: even count
    // Reset and straps
    input  wire logic        reset_input_i,     // Reset contact closed
    input  wire logic        auto_reset_strap_i,// High: automatic reset
    input  wire logic        info_mode_i,       // Low: pos 1, high: pos 2
    // Outputs
    output logic             safety_out_a_o,    // Safety output one
    output logic             safety_out_b_o,    // Safety output two
    output logic             info_output_o,     // Information output
    output logic             irq_o              // Interrupt, level high
);

    // ------------------------------------------------------------
    // Loop evaluation and reset supervision
    // ------------------------------------------------------------
    logic eval;
    logic eval_ok;
    logic loop_valid;
    logic reset_accept;

    loop_tester #(
        .HALF_CYC (HALF_CYC)
    ) u_tester (
        .clk_i           (clk_i),
        .rst_i           (rst_i),
        .loop_receive_i  (loop_receive_i),
        .parity_select_i (parity_select_i),
        .loop_transmit_o (loop_transmit_o),
        .eval_o          (eval),
        .eval_ok_o       (eval_ok),
        .loop_valid_o    (loop_valid)
    );

    reset_detect #(
        .CLOSE_CYC (CLOSE_CYC)
    ) u_reset (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .closed_i (reset_input_i),
        .accept_o (reset_accept)
    );

    // ------------------------------------------------------------
    // Register bus decode
    // ------------------------------------------------------------
    logic                                 ack_r;
    logic [31:0]                          rdata_r;
    logic                                 force_open_r;
    logic [loop_mon_pkg::IRQ_W-1:0]       irq_stat_r;
    logic [loop_mon_pkg::IRQ_W-1:0]       irq_stat_nxt;
    logic [loop_mon_pkg::IRQ_W-1:0]       irq_mask_r;
    logic [loop_mon_pkg::IRQ_W-1:0]       irq_events;
    logic [31:0]                          status_word;
    logic [31:0]                          rdata_nxt;
    logic                                 bus_req;
    logic                                 wr_take;
    logic                                 wr_ctrl;
    logic                                 wr_stat;
    logic                                 wr_mask;

    assign bus_req  = wb_cyc_i && wb_stb_i && !ack_r;
    // Fields live in the low byte; other lanes are ignored
    assign wr_take  = bus_req && wb_we_i && wb_sel_i[0];
    assign wr_ctrl  = wr_take && (wb_adr_i == loop_mon_pkg::CTRL_OFS);
    assign wr_stat  = wr_take && (wb_adr_i == loop_mon_pkg::IRQ_STAT_OFS);
    assign wr_mask  = wr_take && (wb_adr_i == loop_mon_pkg::IRQ_MASK_OFS);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r   <= 1'b0;
            rdata_r <= 32'h0;
        end else begin
            ack_r   <= bus_req;
            rdata_r <= bus_req ? rdata_nxt : 32'h0;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdata_r;

    // ------------------------------------------------------------
    // Output group state machine
    // ------------------------------------------------------------
    loop_mon_pkg::out_state_e state_r;
    loop_mon_pkg::out_state_e state_nxt;
    logic                     go_on;
    logic                     go_off;
    logic                     reset_ok;
    logic                     active;

    // Feedback contacts gate the reset path
    // Auto mode follows the closed reset path
    assign reset_ok = auto_reset_strap_i ? reset_input_i : reset_accept;
    // Valid loop plus a fresh reset, or a closed reset path in auto mode
    assign go_on    = loop_valid && !force_open_r && reset_ok;
    assign go_off   = !loop_valid || force_open_r;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            loop_mon_pkg::ST_OPEN: begin
                if (go_on)
                    state_nxt = loop_mon_pkg::ST_ON;
            end
            loop_mon_pkg::ST_ON: begin
                if (go_off)
                    state_nxt = loop_mon_pkg::ST_OPEN;
            end
            default: begin
                state_nxt = loop_mon_pkg::ST_OPEN;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i)
            state_r <= loop_mon_pkg::ST_OPEN;
        else
            state_r <= state_nxt;
    end

    assign active = (state_r == loop_mon_pkg::ST_ON);

    // ------------------------------------------------------------
    // Safety and information outputs
    // ------------------------------------------------------------
    logic out_a_r;
    logic out_b_r;
    logic info_r;
    logic info_nxt;

    // Position 1 shows the reset state
    assign info_nxt = info_mode_i ? (loop_valid && (state_nxt != loop_mon_pkg::ST_ON))
                                  : (state_nxt == loop_mon_pkg::ST_ON);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_a_r <= 1'b0;
            out_b_r <= 1'b0;
            info_r  <= 1'b0;
        end else begin
            out_a_r <= (state_nxt == loop_mon_pkg::ST_ON);
            out_b_r <= (state_nxt == loop_mon_pkg::ST_ON);
            info_r  <= info_nxt;
        end
    end

    assign safety_out_a_o = out_a_r;
    assign safety_out_b_o = out_b_r;
    assign info_output_o  = info_r;

    // ------------------------------------------------------------
    // Control, status and interrupts
    // ------------------------------------------------------------
    logic valid_q_r;

    assign irq_events[loop_mon_pkg::IRQ_FAULT_BIT] = valid_q_r && !loop_valid;
    assign irq_events[loop_mon_pkg::IRQ_ON_BIT]    = go_on && !active;
    assign irq_events[loop_mon_pkg::IRQ_RESET_BIT] = reset_accept;

    // Set wins over a write-one clear in the same cycle
    assign irq_stat_nxt = (irq_stat_r & ~(wr_stat ? wb_dat_i[loop_mon_pkg::IRQ_W-1:0]
                                                  : loop_mon_pkg::IRQ_RST_VAL))
                          | irq_events;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            force_open_r <= loop_mon_pkg::CTRL_RST_VAL;
            irq_stat_r   <= loop_mon_pkg::IRQ_RST_VAL;
            irq_mask_r   <= loop_mon_pkg::IRQ_RST_VAL;
            valid_q_r    <= 1'b0;
        end else begin
            if (wr_ctrl)
                force_open_r <= wb_dat_i[loop_mon_pkg::CTRL_FORCE_BIT];
            if (wr_mask)
                irq_mask_r <= wb_dat_i[loop_mon_pkg::IRQ_W-1:0];
            irq_stat_r <= irq_stat_nxt;
            valid_q_r  <= loop_valid;
        end
    end

    assign irq_o = |(irq_stat_r & irq_mask_r);

    always_comb begin
        status_word = 32'h0;
        status_word[loop_mon_pkg::ST_VALID_BIT]  = loop_valid;
        status_word[loop_mon_pkg::ST_ACTIVE_BIT] = active;
        status_word[loop_mon_pkg::ST_INFO_BIT]   = info_r;
        status_word[loop_mon_pkg::ST_AUTO_BIT]   = auto_reset_strap_i;
        status_word[loop_mon_pkg::ST_EVEN_BIT]   = parity_select_i;
        status_word[loop_mon_pkg::ST_TX_BIT]     = loop_transmit_o;
        status_word[loop_mon_pkg::ST_MODE2_BIT]  = info_mode_i;
    end

    always_comb begin
        rdata_nxt = 32'h0;
        unique case (wb_adr_i)
            loop_mon_pkg::CTRL_OFS:     rdata_nxt = {31'h0, force_open_r};
            loop_mon_pkg::STATUS_OFS:   rdata_nxt = status_word;
            loop_mon_pkg::IRQ_STAT_OFS: rdata_nxt = {29'h0, irq_stat_r};
            loop_mon_pkg::IRQ_MASK_OFS: rdata_nxt = {29'h0, irq_mask_r};
            default:                    rdata_nxt = 32'h0;
        endcase
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_closed_then_open;
        reset_accept ##0 loop_valid ##0 !force_open_r;
    endsequence

    sequence s_fault;
        active ##0 !loop_valid;
    endsequence

    a_group_equal: assert property (@(posedge clk_i) disable iff (rst_i)
        safety_out_a_o == safety_out_b_o) else $error("safety outputs differ");

    a_fault_opens: assert property (@(posedge clk_i) disable iff (rst_i)
        s_fault |=> !safety_out_a_o && !active) else $error("outputs stayed on after fault");

    a_manual_release: assert property (@(posedge clk_i) disable iff (rst_i)
        !auto_reset_strap_i && !active ##1 active |-> $past(reset_accept))
        else $error("manual mode activated without reset action");

    a_manual_act: assert property (@(posedge clk_i) disable iff (rst_i)
        (!auto_reset_strap_i && !active) ##0 s_closed_then_open |=> active ##1 safety_out_a_o)
        else $error("valid reset action did not activate");

    a_auto_act: assert property (@(posedge clk_i) disable iff (rst_i)
        auto_reset_strap_i && reset_input_i && loop_valid && !force_open_r && !active
        |=> active ##1 safety_out_b_o) else $error("auto reset did not activate");

    a_feedback_block: assert property (@(posedge clk_i) disable iff (rst_i)
        auto_reset_strap_i && !reset_input_i && !active |=> !active)
        else $error("activation with open feedback path");

    a_info_mode1: assert property (@(posedge clk_i) disable iff (rst_i)
        !info_mode_i ##1 !$past(rst_i) |-> info_output_o == active)
        else $error("info output wrong in position 1");

    a_info_mode2: assert property (@(posedge clk_i) disable iff (rst_i)
        info_mode_i && $stable(info_mode_i) && $stable(loop_valid) && $stable(active)
        |-> info_output_o == (loop_valid && !active)) else $error("info output wrong in position 2");

    a_deact_time: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(loop_valid) |-> ##[1:2] !safety_out_a_o) else $error("deactivation too slow");

    a_eval_rate: assert property (@(posedge clk_i) disable iff (rst_i)
        eval |=> !eval [*8]) else $error("evaluation strobe too dense");

    a_fault_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_events[loop_mon_pkg::IRQ_FAULT_BIT] |=> irq_stat_r[loop_mon_pkg::IRQ_FAULT_BIT])
        else $error("fault event lost");

    a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o) else $error("ack held more than one cycle");

endmodule

// *** sensor_chain_model.sv ***
// Behavioural chain of inverting loop sensors
`timescale 1ns/100ps
module sensor_chain_model (
    input  wire logic       loop_transmit_i, // Test signal from monitor
    input  wire logic [3:0] n_sens_i,        // Sensors in series
    input  wire logic       open_i,          // A sensor broke the loop
    input  wire logic       short_i,         // One sensor shorted across
    output logic            loop_receive_o   // Signal back to monitor
);
    // ------------------------------------------------------------
    // Chain behaviour
    // ------------------------------------------------------------
    logic [3:0] inv_count;
    assign inv_count = n_sens_i - {3'h0, short_i};
    assign loop_receive_o = open_i ? 1'b0 : loop_transmit_i ^ inv_count[0];
endmodule

// *** tb.sv ***
// Self-checking bench for the safety loop monitor
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb;
    localparam int HALF  = 16;
    localparam int CLOSE = 20;
    localparam int DEACT = 2 * HALF + 3;
    localparam int ACT   = 3 * HALF + 4;
    logic        clk_i, rst_i, cyc, stb, we, ack, tx, rx, par, rst_in, auto, mode;
    logic        sa, sb, info, irq, open_l, short_l;
    logic [3:0]  sel, n_sens;
    logic [7:0]  adr;
    logic [31:0] dat, rdat, q;
    int          fail_count, n_tests;

    safety_loop_monitor #(.HALF_CYC(HALF), .CLOSE_CYC(CLOSE)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .loop_transmit_o(tx), .loop_receive_i(rx), .parity_select_i(par),
        .reset_input_i(rst_in), .auto_reset_strap_i(auto), .info_mode_i(mode),
        .safety_out_a_o(sa), .safety_out_b_o(sb), .info_output_o(info), .irq_o(irq));
    sensor_chain_model i_chain (.loop_transmit_i(tx), .n_sens_i(n_sens), .open_i(open_l),
        .short_i(short_l), .loop_receive_o(rx));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hf;
        do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 50);
        `CHK("bus_ack", 1'b1, ack)
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask
    task automatic wait_out(input logic v, input int lim);
        int n;
        n = 0;
        while (sa !== v && n < lim) begin @(posedge clk_i); n++; end
        `CHK("out_in_time", v, sa)
        `CHK("out_pair", sa, sb)
    endtask
    task automatic wait_valid();
        int n;
        n = 0;
        q = '0;
        while (q[0] !== 1'b1 && n < 40) begin bus(1'b0, 8'h04, '0); n++; end
        `CHK("loop_valid", 1'b1, q[0])
    endtask
    task automatic reset_action();
        rst_in <= 1'b1;
        repeat (CLOSE + 4) @(posedge clk_i);
        `CHK("closure_only", 1'b0, sa)
        rst_in <= 1'b0;
        wait_out(1'b1, 8);
    endtask
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_wave();
        int n;
        logic p;
        @(posedge clk_i);
        p = tx;
        while (tx === p) @(posedge clk_i);
        n = 0;
        p = tx;
        while (tx === p && n < 100) begin @(posedge clk_i); n++; end
        `CHK("half_period", HALF, n)
    endtask
    task automatic t_regs();
        bus(1'b0, 8'h00, '0); `CHK("ctrl_rst", 32'h0, q)
        bus(1'b0, 8'h0c, '0); `CHK("mask_rst", 32'h0, q)
        bus(1'b1, 8'h0c, 32'h7);
        bus(1'b0, 8'h0c, '0); `CHK("mask_rw", 32'h7, q)
        bus(1'b0, 8'h20, '0); `CHK("unmapped", 32'h0, q)
    endtask
    task automatic t_manual();
        wait_valid();
        `CHK("info_pos1_idle", 1'b0, info)
        reset_action();
        `CHK("info_pos1_set", 1'b1, info)
        bus(1'b0, 8'h08, '0); `CHK("irq_reset", 1'b1, q[2])
    endtask
    task automatic t_fault();
        bus(1'b1, 8'h08, 32'h7);
        open_l <= 1'b1;
        wait_out(1'b0, DEACT);
        `CHK("irq_level", 1'b1, irq)
        bus(1'b0, 8'h08, '0); `CHK("irq_fault", 1'b1, q[0])
        bus(1'b1, 8'h08, 32'h7); `CHK("irq_clear", 1'b0, irq)
        open_l <= 1'b0;
        wait_valid();
        `CHK("stay_open", 1'b0, sa)
        reset_action();
        short_l <= 1'b1;
        wait_out(1'b0, DEACT);
        short_l <= 1'b0;
    endtask
    task automatic t_parity();
        n_sens <= 4'h3;
        repeat (4 * HALF) @(posedge clk_i);
        bus(1'b0, 8'h04, '0); `CHK("odd_refused", 1'b0, q[0])
        par <= 1'b0;
        wait_valid();
    endtask
    task automatic t_auto();
        mode <= 1'b1;
        auto <= 1'b1;
        repeat (2 * HALF) @(posedge clk_i);
        `CHK("feedback_block", 1'b0, sa)
        `CHK("info_pos2_res", 1'b1, info)
        rst_in <= 1'b1;
        wait_out(1'b1, 4);
        `CHK("info_pos2_on", 1'b0, info)
        open_l <= 1'b1;
        wait_out(1'b0, DEACT);
        `CHK("info_pos2_open", 1'b0, info)
        open_l <= 1'b0;
        wait_out(1'b1, ACT);
    endtask

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    initial begin
        #2_000_000;
        fail_count++;
        end_of_test();
    end
    initial begin
        rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = '0; sel = '0; dat = '0;
        par = 1'b1; n_sens = 4'h2; rst_in = 1'b0; auto = 1'b0; mode = 1'b0;
        open_l = 1'b0; short_l = 1'b0; fail_count = 0; n_tests = 0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_wave();
        t_regs();
        t_manual();
        t_fault();
        t_parity();
        t_auto();
        end_of_test();
    end
endmodule
